// ===== rtl/mtsm_mapper.sv
`timescale 1ns/1ps
module mtsm_mapper
	import mtsm_pkg::*;
#(
	parameter int ELEM_CYCLES = ELEM_CYC,
	parameter int BUF_DEPTH = FIFO_DEPTH
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic tx_en_in,
	input wire mtsm_cfg_t cfg_in,
	input wire logic [1:0] din_in,
	input wire logic din_valid_in,
	output logic din_ready_out,
	output mtsm_elem_t elem_out,
	output logic elem_stb_out,
	output logic underrun_out,
	output logic framing_out
);
	if (ELEM_CYCLES < 2 || ELEM_CYCLES >= 2 ** 22) begin : g_bad_elem
		$error("ELEM_CYCLES out of range");
	end
	logic stb, start, apply, load_init, coll, take_d, fifo_valid, full;
	logic lf_load, lf_back, lf_step;
	logic [1:0] fifo_data, lf_bits, bits_in;
	mtsm_cfg_t cfg_q, cfg_d, cfg_sel;
	mtsm_frm_t plan;
	mtsm_st_t st_q, st_d;
	logic [2:0] lg;
	logic [5:0] need;

	mtsm_fifo #(.WIDTH(2), .DEPTH(BUF_DEPTH)) u_fifo (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.in_data_in(din_in), .in_valid_in(din_valid_in), .in_ready_out(din_ready_out),
		.out_data_out(fifo_data), .out_valid_out(fifo_valid), .out_ready_in(take_d));

	mtsm_lfsr u_lfsr (.clock_in(clock_in), .rst_n_in(rst_n_in), .load_in(lf_load), .back_in(lf_back),
		.step_in(lf_step), .bits_out(lf_bits));

	// Element timer
	logic [21:0] tmr_q, tmr_d;
	always_comb begin
		stb = (tmr_q == 22'(ELEM_CYCLES - 1));
		tmr_d = stb ? '0 : tmr_q + 22'h1;
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			tmr_q <= '0;
		end else begin
			tmr_q <= tmr_d;
		end
	end

	// Rate dependent shape of an element
	always_comb begin
		cfg_sel = (st_q == ST_IDLE) ? cfg_in : cfg_q;
		plan = frm_plan(cfg_sel.rate, cfg_sel.degree);
		full = (cfg_q.rate == R2400);
		unique case (cfg_q.rate)
			R75: lg = 3'h4;
			R150: lg = 3'h3;
			R300: lg = 3'h2;
			R600: lg = 3'h1;
			default: lg = 3'h0;
		endcase
		// New dibits per element: 64/d bits, or 78 at full rate
		need = full ? FULL_DIBITS : (DIV_DIBITS >> lg);
	end

	// Transmit sequence control
	logic [3:0] pre_q, pre_d;
	always_comb begin
		st_d = st_q;
		pre_d = pre_q;
		cfg_d = cfg_q;
		start = 1'b0;
		apply = 1'b0;
		load_init = 1'b0;
		if (stb) begin
			unique case (st_q)
				ST_IDLE: begin
					if (tx_en_in) begin
						st_d = ST_PRE;
						start = 1'b1;
						cfg_d = cfg_in;
						pre_d = cfg_in.ext_pre ? PRE3_LAST_EXT : PRE3_LAST_SHORT;
						load_init = 1'b1;
					end
				end
				ST_PRE: begin
					if (pre_q != 4'h0) begin
						pre_d = pre_q - 4'h1;
						load_init = 1'b1;
					end else begin
						st_d = ST_DATA;
						apply = 1'b1;
					end
				end
				ST_DATA: begin
					if (tx_en_in) begin
						apply = 1'b1;
					end else begin
						st_d = ST_IDLE;
					end
				end
				default: st_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			st_q <= ST_IDLE;
			pre_q <= '0;
			cfg_q <= '0;
		end else begin
			st_q <= st_d;
			pre_q <= pre_d;
			cfg_q <= cfg_d;
		end
	end

	// Framing insertion schedule
	mtsm_fr_t fr_q, fr_d;
	logic [9:0] frl_q, frl_d;
	logic [13:0] dcnt_q, dcnt_d;
	logic [5:0] cnt_q, cnt_d;
	always_comb begin
		// Only the last preamble element collects, earlier elements would drop the bits at the strobe
		coll = (st_q == ST_DATA || (st_q == ST_PRE && pre_q == 4'h0)) && !stb && (cnt_q < need);
		fr_d = fr_q;
		frl_d = frl_q;
		dcnt_d = dcnt_q;
		lf_load = 1'b0;
		lf_back = 1'b0;
		lf_step = 1'b0;
		take_d = 1'b0;
		if (start) begin
			// First insertion opens the first data element
			fr_d = FR_PREP;
			lf_load = 1'b1;
			frl_d = plan.len - 10'h1;
			dcnt_d = '0;
		end else if (st_q == ST_IDLE) begin
			fr_d = FR_OFF;
		end else begin
			unique case (fr_q)
				FR_OFF: begin
					if (coll && fifo_valid) begin
						take_d = 1'b1;
						dcnt_d = dcnt_q + 14'h1;
						if (dcnt_q + 14'h1 == plan.ival[14:1]) begin
							fr_d = FR_PREP;
							lf_load = 1'b1;
							frl_d = plan.len - 10'h1;
							dcnt_d = '0;
						end
					end
				end
				FR_PREP: begin
					// Rewind len-1 steps; costs a few hundred clocks, far below one element
					lf_back = 1'b1;
					frl_d = frl_q - 10'h1;
					if (frl_q == 10'h1) begin
						fr_d = FR_SEND;
						frl_d = {1'b0, plan.len[9:1]};
					end
				end
				FR_SEND: begin
					if (coll) begin
						lf_step = 1'b1;
						frl_d = frl_q - 10'h1;
						if (frl_q == 10'h1) begin
							fr_d = FR_OFF;
						end
					end
				end
				default: fr_d = FR_OFF;
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			fr_q <= FR_OFF;
			frl_q <= '0;
			dcnt_q <= '0;
		end else begin
			fr_q <= fr_d;
			frl_q <= frl_d;
			dcnt_q <= dcnt_d;
		end
	end

	// Dibit collector for the next element
	logic [ACC_BITS-1:0] acc_q, acc_d;
	logic frs_q, frs_d;
	always_comb begin
		bits_in = take_d ? fifo_data : lf_bits;
		acc_d = acc_q;
		cnt_d = cnt_q;
		frs_d = frs_q || lf_step;
		if (stb) begin
			acc_d = '0;
			cnt_d = '0;
			frs_d = 1'b0;
		end else if (take_d || lf_step) begin
			// Earlier bit in the low position of each pair
			acc_d[{cnt_q, 1'b0} +: 2] = bits_in;
			cnt_d = cnt_q + 6'h1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			acc_q <= '0;
			cnt_q <= '0;
			frs_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			cnt_q <= cnt_d;
			frs_q <= frs_d;
		end
	end

	// Word history and bit-to-tone map
	logic [TF_BITS-1:0] hist_q [HIST];
	logic [TF_BITS-1:0] hist_d [HIST];
	logic [3:0] wp_q, wp_d;
	logic [ACC_BITS-1:0] ev;
	always_comb begin
		int j;
		int dly;
		int b;
		j = 0;
		dly = 0;
		b = 0;
		ev = '0;
		for (int p = 0; p < TF_BITS; p++) begin
			j = p >> (6 - lg);
			dly = j << (4 - lg);
			b = p & ((TF_BITS >> lg) - 1);
			if (cfg_q.div == DIV_TF && dly != 0) begin
				ev[p] = hist_q[4'(wp_q - 4'(dly))][b[5:0]];
			end else begin
				// Frequency-only repeats the word inside the element
				ev[p] = acc_q[b[6:0]];
			end
		end
		ev[ACC_BITS-1:TF_BITS] = full ? acc_q[ACC_BITS-1:TF_BITS] : ev[13:0];
		hist_d = hist_q;
		wp_d = wp_q;
		if (start) begin
			hist_d = '{default: '0};
			wp_d = '0;
		end else if (apply) begin
			hist_d[wp_q] = acc_q[TF_BITS-1:0];
			wp_d = wp_q + 4'h1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			hist_q <= '{default: '0};
			wp_q <= '0;
		end else begin
			hist_q <= hist_d;
			wp_q <= wp_d;
		end
	end

	// Tone phases, all moved on the same strobe
	logic [TONES-1:0][PH_W-1:0] ph_q, ph_d;
	function automatic logic [PH_W-1:0] phase_inc(input logic [1:0] d);
		unique case (d)
			2'h2: return INC_MS;
			2'h0: return INC_SS;
			2'h1: return INC_SM;
			2'h3: return INC_MM;
		endcase
	endfunction

	always_comb begin
		ph_d = ph_q;
		if (load_init) begin
			for (int t = 0; t < TONES; t++) begin
				ph_d[t] = PH_INIT[t];
			end
		end else if (apply) begin
			for (int t = 0; t < TONES; t++) begin
				// Wraps modulo one turn; 12-bit phase keeps synthesis error tiny
				ph_d[t] = ph_q[t] + phase_inc(ev[2 * t + 1 -: 2]);
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			ph_q <= '0;
		end else begin
			ph_q <= ph_d;
		end
	end

	// Output flags and amplitudes
	logic [1:0] tamp_q, tamp_d, damp_q, damp_d;
	logic dat_q, dat_d, stbo_q, stbo_d, und_q, und_d, frm_q, frm_d;
	always_comb begin
		tamp_d = tamp_q;
		damp_d = damp_q;
		dat_d = dat_q;
		frm_d = frm_q;
		// Also pulse on the drop to idle, so the silenced amplitudes are marked
		stbo_d = stb && (st_q != ST_IDLE || st_d != ST_IDLE);
		und_d = apply && (cnt_q < need);
		if (stb) begin
			tamp_d = (st_d == ST_IDLE) ? AMP_OFF : AMP_DATA;
			damp_d = (st_d == ST_IDLE) ? AMP_OFF : AMP_DOP;
			dat_d = (st_d == ST_DATA);
			frm_d = apply && frs_q;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			tamp_q <= AMP_OFF;
			damp_q <= AMP_OFF;
			dat_q <= 1'b0;
			stbo_q <= 1'b0;
			und_q <= 1'b0;
			frm_q <= 1'b0;
		end else begin
			tamp_q <= tamp_d;
			damp_q <= damp_d;
			dat_q <= dat_d;
			stbo_q <= stbo_d;
			und_q <= und_d;
			frm_q <= frm_d;
		end
	end

	assign elem_out = '{phase: ph_q, tone_amp: tamp_q, dop_amp: damp_q, data: dat_q};
	assign elem_stb_out = stbo_q;
	assign underrun_out = und_q;
	assign framing_out = frm_q;
endmodule

// ===== include/mtsm_pkg.sv
package mtsm_pkg;
	localparam int TONES = 39;
	localparam int PH_W = 12;
	localparam int ELEM_US = 22500;
	localparam int CLK_MHZ = 125;
	localparam int ELEM_CYC = ELEM_US * CLK_MHZ;
	localparam int FIFO_DEPTH = 8;
	localparam int HIST = 16;
	localparam int ACC_BITS = 78;
	localparam int TF_BITS = 64;
	localparam logic [5:0] FULL_DIBITS = 6'h27;
	localparam logic [5:0] DIV_DIBITS = 6'h20;
	localparam logic [3:0] PRE3_LAST_SHORT = 4'h0;
	localparam logic [3:0] PRE3_LAST_EXT = 4'hB;
	localparam logic [8:0] LFSR_LAST = 9'h1FF;
	localparam logic [1:0] AMP_OFF = 2'h0;
	localparam logic [1:0] AMP_DATA = 2'h1;
	localparam logic [1:0] AMP_DOP = 2'h2;
	// Phase unit is one 4096th of a turn
	localparam logic [PH_W-1:0] INC_MS = 12'h200;
	localparam logic [PH_W-1:0] INC_SS = 12'h600;
	localparam logic [PH_W-1:0] INC_SM = 12'hA00;
	localparam logic [PH_W-1:0] INC_MM = 12'hE00;
	localparam logic [PH_W-1:0] PH_INIT [TONES] = '{
		12'h000, 12'h040, 12'h0E0, 12'h1E0, 12'h340, 12'h520, 12'h760, 12'hA00,
		12'hD20, 12'h0A0, 12'h481, 12'h8E0, 12'hD81, 12'h2A0, 12'h840, 12'hE20,
		12'h481, 12'hB40, 12'h281, 12'hA00, 12'h200, 12'hA81, 12'h340, 12'hC81,
		12'h620, 12'h040, 12'hAA0, 12'h581, 12'h0E0, 12'hC81, 12'h8A0, 12'h520,
		12'h200, 12'hF60, 12'hD20, 12'hB40, 12'h9E0, 12'h8E0, 12'h840};

	typedef enum logic [2:0] {R75, R150, R300, R600, R1200, R2400} mtsm_rate_t;
	typedef enum logic {DIV_TF, DIV_FREQ} mtsm_div_t;
	typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_DATA} mtsm_st_t;
	typedef enum logic [1:0] {FR_OFF, FR_PREP, FR_SEND} mtsm_fr_t;

	typedef struct packed {
		mtsm_rate_t rate;
		mtsm_div_t div;
		logic [2:0] degree;
		logic ext_pre;
	} mtsm_cfg_t;

	typedef struct packed {
		logic [TONES-1:0][PH_W-1:0] phase;
		logic [1:0] tone_amp;
		logic [1:0] dop_amp;
		logic data;
	} mtsm_elem_t;

	typedef struct packed {
		logic [14:0] ival;
		logic [9:0] len;
	} mtsm_frm_t;

	// Insertion interval (data bits) and sequence length per rate and degree
	function automatic mtsm_frm_t frm_plan(input mtsm_rate_t r, input logic [2:0] g);
		case ({r, g})
			{R75, 3'h0}, {R300, 3'h0}, {R600, 3'h0}, {R1200, 3'h0}, {R1200, 3'h3}: return '{15'h3E04, 10'h0FC};
			{R75, 3'h1}: return '{15'h6660, 10'h1A0};
			{R75, 3'h2}, {R150, 3'h1}, {R150, 3'h2}: return '{15'h6270, 10'h190};
			{R75, 3'h3}, {R150, 3'h0}: return '{15'h3F00, 10'h100};
			{R150, 3'h3}: return '{15'h46E0, 10'h120};
			{R300, 3'h1}: return '{15'h6468, 10'h198};
			{R300, 3'h2}: return '{15'h5C88, 10'h178};
			{R300, 3'h3}: return '{15'h42F0, 10'h110};
			{R600, 3'h1}, {R600, 3'h2}: return '{15'h6C48, 10'h1B8};
			{R600, 3'h3}: return '{15'h40F8, 10'h108};
			{R1200, 3'h1}: return '{15'h6078, 10'h188};
			{R1200, 3'h2}: return '{15'h7C08, 10'h1F8};
			{R2400, 3'h2}, {R2400, 3'h5}: return '{15'h2F40, 10'h180};
			{R2400, 3'h3}: return '{15'h3528, 10'h1B0};
			{R2400, 3'h4}: return '{15'h3720, 10'h1C0};
			{R2400, 3'h7}: return '{15'h3F00, 10'h200};
			default: return '{15'h1F80, 10'h100};
		endcase
	endfunction
endpackage

// ===== rtl/mtsm_fifo.sv
`timescale 1ns/1ps
module mtsm_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 8
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [WIDTH-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
		$error("FIFO needs WIDTH >= 1 and a power-of-two DEPTH >= 2");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic rdy_q, rdy_d, push, pop;

	assign in_ready_out = rdy_q;
	assign out_valid_out = (cnt_q != '0);
	assign out_data_out = mem_q[rd_q];

	always_comb begin
		push = in_valid_in && rdy_q;
		pop = out_valid_out && out_ready_in;
		mem_d = mem_q;
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wr_q] = in_data_in;
			wr_d = wr_q + 1'b1;
			cnt_d = cnt_d + 1'b1;
		end
		if (pop) begin
			rd_d = rd_q + 1'b1;
			cnt_d = cnt_d - 1'b1;
		end
		// Registered ready so the source sees back-pressure from a flop
		rdy_d = (cnt_d != (AW + 1)'(DEPTH));
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			mem_q <= '{default: '0};
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			rdy_q <= 1'b1;
		end else begin
			mem_q <= mem_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			rdy_q <= rdy_d;
		end
	end
endmodule

// ===== rtl/mtsm_lfsr.sv
`timescale 1ns/1ps
module mtsm_lfsr
	import mtsm_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic load_in,
	input wire logic back_in,
	input wire logic step_in,
	output logic [1:0] bits_out
);
	logic [8:0] st_q, st_d, s1;

	// Taps of x^9 + x^7 + x^6 + x^4 + 1
	function automatic logic fb(input logic [8:0] s);
		return s[8] ^ s[6] ^ s[5] ^ s[3];
	endfunction

	always_comb begin
		s1 = {st_q[7:0], fb(st_q)};
		bits_out = {fb(s1), fb(st_q)};
		st_d = st_q;
		if (load_in) begin
			st_d = LFSR_LAST;
		end else if (back_in) begin
			// One step backwards, so the run ends on the all-ones state
			st_d = {st_q[0] ^ st_q[7] ^ st_q[6] ^ st_q[4], st_q[8:1]};
		end else if (step_in) begin
			st_d = {s1[7:0], fb(s1)};
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			st_q <= LFSR_LAST;
		end else begin
			st_q <= st_d;
		end
	end
endmodule

// ===== testbench/mtsm_mapper_chk.sv
`timescale 1ns/1ps
module mtsm_mapper_chk
	import mtsm_pkg::*;
#(
	parameter int ELEM_CYCLES = ELEM_CYC
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire mtsm_cfg_t cfg_in,
	input wire mtsm_elem_t elem_out,
	input wire logic elem_stb_out,
	input wire logic underrun_out,
	input wire logic framing_out
);
	int gap_q, gap_d;
	logic seen_q, seen_d;
	logic [TONES-1:0][PH_W-1:0] prev_q, prev_d;

	// Phases of the previous element, to judge each advance
	always_comb begin
		gap_d = elem_stb_out ? 0 : gap_q + 1;
		seen_d = seen_q | elem_stb_out;
		prev_d = elem_stb_out ? elem_out.phase : prev_q;
	end
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			gap_q <= 0;
			seen_q <= 1'b0;
			prev_q <= '0;
		end else begin
			gap_q <= gap_d;
			seen_q <= seen_d;
			prev_q <= prev_d;
		end
	end

	function automatic logic diff_ok(input logic [TONES-1:0][PH_W-1:0] a, input logic [TONES-1:0][PH_W-1:0] b);
		diff_ok = 1'b1;
		for (int t = 0; t < TONES; t++)
			if (!(PH_W'(a[t] - b[t]) inside {12'h200, 12'h600, 12'hA00, 12'hE00}))
				diff_ok = 1'b0;
	endfunction
	function automatic logic copy_ok(input logic [TONES-1:0][PH_W-1:0] a, input logic [TONES-1:0][PH_W-1:0] b);
		copy_ok = 1'b1;
		for (int t = 32; t < TONES; t++)
			if (PH_W'(a[t] - b[t]) != PH_W'(a[t - 32] - b[t - 32]))
				copy_ok = 1'b0;
	endfunction
	function automatic logic pre_ok(input logic [TONES-1:0][PH_W-1:0] a);
		pre_ok = 1'b1;
		for (int t = 0; t < TONES; t++)
			if (a[t] != PH_INIT[t])
				pre_ok = 1'b0;
	endfunction

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_stb;
		elem_stb_out;
	endsequence
	sequence s_data;
		elem_stb_out && elem_out.data;
	endsequence

	property p_stb_pulse; s_stb |=> !elem_stb_out; endproperty
	property p_stb_period; s_stb and seen_q |-> (gap_q + 1) % ELEM_CYCLES == 0; endproperty
	property p_keyed; $changed(elem_out) |-> elem_stb_out; endproperty
	property p_frm_elem; $changed(framing_out) |-> elem_stb_out; endproperty
	property p_underrun; underrun_out |-> s_data; endproperty
	property p_dop; s_data |-> elem_out.dop_amp == AMP_DOP && elem_out.tone_amp == AMP_DATA; endproperty
	property p_pre_phase; s_stb and !elem_out.data && elem_out.tone_amp == AMP_DATA |-> pre_ok(elem_out.phase);
	endproperty
	property p_inc; s_data and seen_q |-> diff_ok(elem_out.phase, prev_q); endproperty
	property p_upper; s_data and seen_q && cfg_in.rate != R2400 |-> copy_ok(elem_out.phase, prev_q); endproperty
	property p_first; $rose(rst_n_in) |-> (!elem_stb_out) [*8]; endproperty

	a_stb_pulse: assert property (p_stb_pulse) else $error("strobe wider than one cycle");
	a_stb_period: assert property (p_stb_period) else $error("element period wrong");
	a_keyed: assert property (p_keyed) else $error("element output moved off strobe");
	a_frm_elem: assert property (p_frm_elem) else $error("framing flag moved off strobe");
	a_underrun: assert property (p_underrun) else $error("underrun outside data element");
	a_dop: assert property (p_dop) else $error("data element amplitudes wrong");
	a_pre_phase: assert property (p_pre_phase) else $error("preamble phases wrong");
	a_inc: assert property (p_inc) else $error("illegal phase advance");
	a_upper: assert property (p_upper) else $error("upper tones differ from lower");
	a_first: assert property (p_first) else $error("strobe too soon after reset");
endmodule

// ===== testbench/mtsm_src.sv
`timescale 1ns/1ps
module mtsm_src (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [1:0] mode_in,
	output logic [1:0] din_out,
	output logic valid_out,
	input wire logic ready_in
);
	// Mode 0 prompt, 1 random gaps, 2 silent
	logic [1:0] sent [$];
	logic offer;

	initial begin
		din_out = 2'h0;
		valid_out = 1'b0;
	end
	always @(posedge clock_in) begin
		if (!rst_n_in) begin
			sent.delete();
			valid_out <= #1 1'b0;
		end else begin
			if (valid_out && ready_in)
				sent.push_back(din_out);
			if (!valid_out || ready_in) begin
				offer = mode_in == 2'h0 || (mode_in == 2'h1 && $urandom_range(1) == 1);
				valid_out <= #1 offer;
				// Idle line toggles so a stale dibit never looks valid
				din_out <= #1 offer ? 2'($urandom) : ~din_out;
			end
		end
	end
endmodule

// ===== testbench/test_multitone_symbol_mapper.sv
`timescale 1ns/1ps
module test_multitone_symbol_mapper;
	import mtsm_pkg::*;
	// Short element keeps the run small, still above the longest rewind
	localparam int ELEM_CYCLES = 700;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic tx_en_in = 1'b0;
	logic [1:0] src_mode = 2'h0;
	mtsm_cfg_t cfg_in = '0;
	logic [1:0] din_in;
	logic din_valid_in, din_ready_out, elem_stb_out, underrun_out, framing_out;
	mtsm_elem_t elem_out;
	int failures = 0;
	int checks_done = 0;
	logic [PH_W-1:0] last_ph [TONES];

	always #4 clock_in = ~clock_in;

	mtsm_src mtsm_src_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .mode_in(src_mode), .din_out(din_in),
		.valid_out(din_valid_in), .ready_in(din_ready_out));
	mtsm_mapper #(.ELEM_CYCLES(ELEM_CYCLES)) mtsm_mapper_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.tx_en_in(tx_en_in), .cfg_in(cfg_in), .din_in(din_in), .din_valid_in(din_valid_in),
		.din_ready_out(din_ready_out), .elem_out(elem_out), .elem_stb_out(elem_stb_out),
		.underrun_out(underrun_out), .framing_out(framing_out));

	task automatic cmp_ph(input string what, input logic [PH_W-1:0] exp, input logic [PH_W-1:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmp_flag(input string what, input logic [3:0] exp, input logic [3:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [PH_W-1:0] inc_of(input logic [1:0] d);
		case (d)
			2'h2: return 12'h200;
			2'h0: return 12'h600;
			2'h1: return 12'hA00;
			default: return 12'hE00;
		endcase
	endfunction
	function automatic logic [PH_W-1:0] inc(input int t);
		return elem_out.phase[t] - last_ph[t];
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic next_elem();
		int n;
		n = 0;
		for (int t = 0; t < TONES; t++)
			last_ph[t] = elem_out.phase[t];
		@(posedge clock_in) #1;
		while (elem_stb_out !== 1'b1 && n < 2 * ELEM_CYCLES) begin
			@(posedge clock_in) #1;
			n++;
		end
		cmp_flag("element strobe", 4'h1, {3'h0, elem_stb_out});
	endtask
	task automatic start(input mtsm_rate_t r, input mtsm_div_t dv, input logic [2:0] g, input logic ext,
		input logic [1:0] m);
		rst_n_in = 1'b0;
		tx_en_in = 1'b0;
		repeat (20) @(posedge clock_in) #1;
		cmp_flag("reset outputs", 4'h8, {din_ready_out, elem_stb_out, underrun_out, framing_out});
		cfg_in = '{r, dv, g, ext};
		src_mode = m;
		tx_en_in = 1'b1;
		rst_n_in = 1'b1;
	endtask

	initial begin
		int n;
		void'($urandom(32'hEAE81F5B));
		start(R1200, DIV_TF, 3'h0, 1'b0, 2'h0);
		next_elem();
		for (int t = 0; t < TONES; t++)
			cmp_ph("preamble phase", PH_INIT[t], elem_out.phase[t]);
		cmp_flag("preamble amps", {AMP_DATA, AMP_DOP}, {elem_out.tone_amp, elem_out.dop_amp});
		cmp_flag("ready when full", 4'h0, {3'h0, din_ready_out});
		cmp_flag("dibits buffered", 4'h8, 4'(mtsm_src_i.sent.size()));
		for (int e = 1; e <= 5; e++) begin
			next_elem();
			cmp_flag("framing element", {3'h0, e < 5}, {3'h0, framing_out});
			cmp_flag("data element", 4'h1, {3'h0, elem_out.data});
		end
		// Framing fills 126 dibits, so element five carries data dibits 2 to 33
		for (int t = 0; t < TONES; t++)
			cmp_ph("tone increment", inc_of(mtsm_src_i.sent[(t % 32) + 2]), inc(t));
		cmp_flag("underrun", 4'h0, {3'h0, underrun_out});
		$display("test mapping done");
		for (int k = 0; k < 8; k++) begin
			start(mtsm_rate_t'(k % 4), mtsm_div_t'(k / 4), 3'($urandom_range(3)), 1'b0, 2'h1);
			next_elem();
			next_elem();
			n = 2 << (k % 4);
			for (int t = n; t < 32; t++)
				cmp_ph("diversity copy", (k < 4) ? 12'h600 : inc(t % n), inc(t));
			$display("test diversity %0d done", k);
		end
		start(R2400, DIV_TF, 3'h0, 1'b1, 2'h0);
		for (int e = 0; e < 13; e++) begin
			next_elem();
			cmp_flag("data element", {3'h0, e == 12}, {3'h0, elem_out.data});
			cmp_flag("framing after preamble", {3'h0, e == 12}, {3'h0, framing_out});
			if (e < 12)
				for (int t = 0; t < TONES; t++)
					cmp_ph("reloaded phase", PH_INIT[t], elem_out.phase[t]);
		end
		$display("test extended preamble done");
		start(R2400, DIV_TF, 3'h0, 1'b0, 2'h2);
		for (int e = 0; e < 5; e++) begin
			next_elem();
			cmp_flag("underrun", {3'h0, e == 4}, {3'h0, underrun_out});
		end
		// Eleven framing dibits lead element four, the missing rest go as zero
		for (int t = 11; t < TONES; t++)
			cmp_ph("starved increment", 12'h600, inc(t));
		$display("test underrun done");
		tx_en_in = 1'b0;
		next_elem();
		cmp_flag("idle amps", 4'h0, {elem_out.tone_amp, elem_out.dop_amp});
		cmp_flag("idle data flag", 4'h0, {3'h0, elem_out.data});
		$display("test shutdown done");
		print_verdict();
	end

	initial begin
		#(70 * ELEM_CYCLES * 8);
		failures++;
		$display("unexpected run length: expected finish seen timeout");
		print_verdict();
	end
endmodule

bind mtsm_mapper mtsm_mapper_chk #(.ELEM_CYCLES(ELEM_CYCLES)) mtsm_mapper_chk_i (.clock_in(clock_in),
	.rst_n_in(rst_n_in), .cfg_in(cfg_in), .elem_out(elem_out), .elem_stb_out(elem_stb_out),
	.underrun_out(underrun_out), .framing_out(framing_out));
